// *** ssm_defines.vh ***
// register map, field positions and reset values for the spi status/data master core
// assumes a 32-bit axi4-lite slave with each register on one aligned word
// Operation
// R1: receive-full flag, status bit 7, sets once a byte lands in the data register.
// R2: receive-full clears on status read seeing it set, then data register read.
// R3: transmit-empty bit 5; armed status read then data write clears it, else write ignored.
// R4: mode-fault flag bit 4 sets when select input low as master with detection on; the code also requires select output off.
// R5: mode-fault clears after a status read seeing it, then a control-one write.
// R6: status readable any time; writes to it change no flag.
// R7: 8-bit data register resets to zero; reads give receive data, writes load transmit.
// R8: as master, a queued byte starts right after the previous transfer ends.
// R9: finished byte with receive-full clear is copied to data register, flag set.
// R10: second byte with flag still set stays pending; data register unchanged.
// R11: pending byte moves in if serviced before the next start, else is discarded.
// R12: port enable dedicates select, clock and both data pins to the core.
// R13: a transfer shifts eight bits, exchanging bytes with the remote end.
// R14: polarity inverts the clock; phase picks odd or even sampling edges.
// R15: controller select set means master, clear means slave; no slave mode is built, clear leaves the core idle.
// R16: master config change aborts the transfer to idle; software resets remote.
// R17: only a master starts; data write loads the empty shift register immediately.
// R18: prescale and shift fields set baud rate, driven on the clock pin.
// R19: with detection and select output on, select low during transfer, high idle.
// R20: fault clears controller select, releases clock and data pins, aborts to idle.
// R21: interrupt requested when mode fault sets with interrupt enable on.
// R22: after a data write, wait half a serial clock period before clocking.
// R23: divisor is (prescale+1) times two to the (shift+1); clock is bus clock over it.
`ifndef SSM_DEFINES_VH
`define SSM_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SSM_IDX_CR1       10'h0E8
`define SSM_IDX_CR2       10'h0E9
`define SSM_IDX_BAUD      10'h0EA
`define SSM_IDX_STATUS    10'h0EB
`define SSM_IDX_DATA      10'h0ED

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SSM_CR1_IRQ_EN    7
`define SSM_CR1_PORT_EN   6
`define SSM_CR1_CTRL_SEL  4
`define SSM_CR1_POL       3
`define SSM_CR1_PHASE     2
`define SSM_CR1_SEL_OUT   1
`define SSM_CR1_LSB       0
`define SSM_CR2_MF_EN     4
`define SSM_CR2_BIDIR_OE  3
`define SSM_CR2_PIN_MODE  0
`define SSM_ST_RX_FULL    7
`define SSM_ST_TX_EMPTY   5
`define SSM_ST_MF         4

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define SSM_CR1_ABORT_MSK 8'h0F
`define SSM_CR2_WR_MSK    8'h19
`define SSM_CR2_ABT_MSK   8'h11
`define SSM_BAUD_WR_MSK   8'h77
`define SSM_CR1_RST       8'h00
`define SSM_CR2_RST       8'h00
`define SSM_BAUD_RST      8'h00
`define SSM_DATA_RST      8'h00
`define SSM_LAST_EDGE     5'h10
`define SSM_RESP_OKAY     2'h0
`define SSM_RESP_SLVERR   2'h2

`endif

// *** ssm_core.v ***
// spi master core: status flags, shared data register, baud generator, mode fault
// assumes one 250 mhz bus clock; serial pins arrive asynchronously and are synchronised
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ssm_defines.vh"

module ssm_core #(
  parameter ADDR_W = 12
) (
  input  wire              core_clk,
  input  wire              rst_n,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              ss_n_in,
  output reg               ss_n_out,
  output reg               ss_n_oe,
  input  wire              sck_in,
  output reg               sck_out,
  output reg               sck_oe,
  input  wire              mosi_in,
  output reg               mosi_out,
  output reg               mosi_oe,
  input  wire              miso_in,
  output reg               miso_out,
  output reg               miso_oe,
  output reg               irq_req
);

  // ----------------------------------------------------------------
  // states and shift helper
  // ----------------------------------------------------------------
  localparam S_IDLE  = 2'b00;
  localparam S_LEAD  = 2'b01;
  localparam S_SHIFT = 2'b10;
  localparam S_TAIL  = 2'b11;

  // shift one bit in at the end selected by bit order
  function [7:0] ssm_shift;
    input [7:0] cur;
    input       bit_in;
    input       lsb;
    begin
      ssm_shift = lsb ? {bit_in, cur[7:1]} : {cur[6:0], bit_in};
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [7:0]        cr1;
  reg [7:0]        cr2;
  reg [7:0]        baud;
  reg [7:0]        rx_data;
  reg [7:0]        tx_buf;
  reg [7:0]        pend_byte;
  reg [7:0]        shreg;
  reg              rx_full_flag;
  reg              tx_empty_flag;
  reg              mode_fault_flag;
  reg              rx_armed;
  reg              tx_armed;
  reg              mf_armed;
  reg              rx_pend;
  reg              rx_bit;
  reg              sck_int;
  reg [1:0]        state;
  reg [10:0]       div_cnt;
  reg [4:0]        edge_cnt;
  reg              aw_got;
  reg              w_got;
  reg [ADDR_W-1:0] aw_addr;
  reg [7:0]        w_byte;
  reg              w_lane0;
  reg [2:0]        ss_sync;
  reg [1:0]        miso_sync;
  reg [1:0]        mosi_sync;
  reg [7:0]        rd_val;
  reg              rd_hit;
  reg [10:0]       half_lim;

  // ----------------------------------------------------------------
  // decode of configuration and bus events
  // ----------------------------------------------------------------
  wire       irq_en               = cr1[`SSM_CR1_IRQ_EN];
  wire       port_enable          = cr1[`SSM_CR1_PORT_EN];
  wire       controller_select    = cr1[`SSM_CR1_CTRL_SEL];
  wire       clk_polarity         = cr1[`SSM_CR1_POL];
  wire       clk_phase            = cr1[`SSM_CR1_PHASE];
  wire       select_out_en        = cr1[`SSM_CR1_SEL_OUT];
  wire       lsb_first_en         = cr1[`SSM_CR1_LSB];
  wire       mode_fault_detect_en = cr2[`SSM_CR2_MF_EN];
  wire       bidir_out_en         = cr2[`SSM_CR2_BIDIR_OE];
  wire       bidir_pin_mode       = cr2[`SSM_CR2_PIN_MODE];
  wire [2:0] baud_prescale        = baud[6:4];
  wire [2:0] baud_shift_sel       = baud[2:0];

  wire master_active = port_enable & controller_select; // [R15] [R12]
  wire wr_go   = aw_got & w_got & ~s_axi_bvalid;
  wire [9:0] wr_idx = aw_addr[11:2];
  wire [9:0] rd_idx = s_axi_araddr[11:2];
  wire wr_ok   = wr_go & w_lane0;
  wire wr_cr1  = wr_ok & (wr_idx == `SSM_IDX_CR1);
  wire wr_cr2  = wr_ok & (wr_idx == `SSM_IDX_CR2);
  wire wr_baud = wr_ok & (wr_idx == `SSM_IDX_BAUD);
  wire wr_data = wr_ok & (wr_idx == `SSM_IDX_DATA);
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire rd_stat = rd_fire & (rd_idx == `SSM_IDX_STATUS);
  wire rd_data = rd_fire & (rd_idx == `SSM_IDX_DATA);

  // settings whose change kills a master transfer; bidir enable only counts in single-wire
  wire [7:0] cr2_abt_msk = bidir_pin_mode ? `SSM_CR2_WR_MSK : `SSM_CR2_ABT_MSK;
  wire cfg_chg = (wr_cr1 & (((w_byte ^ cr1) & `SSM_CR1_ABORT_MSK) != 8'h00))
               | (wr_cr2 & (((w_byte ^ cr2) & cr2_abt_msk) != 8'h00))
               | (wr_baud & (((w_byte ^ baud) & `SSM_BAUD_WR_MSK) != 8'h00));

  // a low select input is someone else driving the bus
  wire fault = master_active & mode_fault_detect_en & ~select_out_en & ~ss_sync[2]; // [R4] [R20]
  wire abort = master_active & (cfg_chg | fault) & (state != S_IDLE);               // [R16]
  wire start = (state == S_IDLE) & master_active & ~tx_empty_flag & ~fault;         // [R8] [R17]

  wire       tick    = (div_cnt == half_lim);
  wire [4:0] next_edge = edge_cnt + 5'h01;
  wire       odd_edge  = next_edge[0];
  wire       din     = bidir_pin_mode ? mosi_sync[1] : miso_sync[1];
  wire       dout    = lsb_first_en ? shreg[0] : shreg[7];
  wire       done    = (state == S_TAIL) & tick & ~abort;
  // phase one leaves the last latched bit unshifted until the tail ends
  wire [7:0] fin_byte = clk_phase ? ssm_shift(shreg, rx_bit, lsb_first_en) : shreg;
  wire       svc     = rd_data & rx_armed;

  // ----------------------------------------------------------------
  // baud generator: half period is (prescale+1) << shift cycles
  // ----------------------------------------------------------------
  always @* begin
    half_lim = ({7'h00, {1'b0, baud_prescale} + 4'h1} << baud_shift_sel) - 11'h001; // [R23] [R18]
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // first stage only feeds the second; ss takes a third stage before the fault logic
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ss_sync   <= 3'h7;
      miso_sync <= 2'h0;
      mosi_sync <= 2'h0;
    end else begin
      ss_sync   <= {ss_sync[1], ss_sync[0], ss_n_in};
      miso_sync <= {miso_sync[0], miso_in};
      mosi_sync <= {mosi_sync[0], mosi_in};
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------------------------------
  // address and data are taken independently; the write lands when both are held
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSM_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `SSM_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= {ADDR_W{1'b0}};
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_got        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_byte       <= s_axi_wdata[7:0];
        w_lane0      <= s_axi_wstrb[0];
        w_got        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_idx == `SSM_IDX_CR1 || wr_idx == `SSM_IDX_CR2 ||
                         wr_idx == `SSM_IDX_BAUD || wr_idx == `SSM_IDX_STATUS ||
                         wr_idx == `SSM_IDX_DATA) ? `SSM_RESP_OKAY : `SSM_RESP_SLVERR;
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_val};
        s_axi_rresp   <= rd_hit ? `SSM_RESP_OKAY : `SSM_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // read multiplexer; status is plain state, reading it has only arming effects
  always @* begin
    rd_hit = 1'b1;
    case (rd_idx)
      `SSM_IDX_CR1:    rd_val = cr1;
      `SSM_IDX_CR2:    rd_val = cr2;
      `SSM_IDX_BAUD:   rd_val = baud;
      `SSM_IDX_STATUS: rd_val = {rx_full_flag, 1'b0, tx_empty_flag, mode_fault_flag, 4'h0}; // [R6]
      `SSM_IDX_DATA:   rd_val = rx_data;                                                   // [R7]
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers, flags and transfer engine
  // ----------------------------------------------------------------
  // one process so that every flag has one driver and later lines win
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cr1             <= `SSM_CR1_RST;
      cr2             <= `SSM_CR2_RST;
      baud            <= `SSM_BAUD_RST;
      rx_data         <= `SSM_DATA_RST;
      tx_buf          <= `SSM_DATA_RST;
      pend_byte       <= 8'h00;
      shreg           <= 8'h00;
      rx_full_flag    <= 1'b0;
      tx_empty_flag   <= 1'b1;
      mode_fault_flag <= 1'b0;
      rx_armed        <= 1'b0;
      tx_armed        <= 1'b0;
      mf_armed        <= 1'b0;
      rx_pend         <= 1'b0;
      rx_bit          <= 1'b0;
      sck_int         <= 1'b0;
      state           <= S_IDLE;
      div_cnt         <= 11'h000;
      edge_cnt        <= 5'h00;
    end else begin
      // status reads arm the clear sequences; writes to status do nothing
      if (rd_stat) begin
        rx_armed <= rx_full_flag;
        tx_armed <= tx_empty_flag;
        mf_armed <= mode_fault_flag;
      end
      if (wr_cr1) begin
        cr1 <= w_byte;
        if (mf_armed) begin
          mode_fault_flag <= 1'b0; // [R5]
          mf_armed        <= 1'b0;
        end
      end
      if (wr_cr2) begin
        cr2 <= w_byte & `SSM_CR2_WR_MSK;
      end
      if (wr_baud) begin
        baud <= w_byte & `SSM_BAUD_WR_MSK;
      end
      // a data write without the armed status read is dropped
      if (wr_data) begin
        tx_armed <= 1'b0;
        if (tx_armed) begin
          tx_buf        <= w_byte;  // [R7]
          tx_empty_flag <= 1'b0;    // [R3]
        end
      end
      // servicing pulls a pending byte forward and keeps the flag up
      if (rd_data) begin
        rx_armed <= 1'b0;
        if (svc) begin
          if (rx_pend) begin
            rx_data <= pend_byte; // [R11]
            rx_pend <= 1'b0;
          end else begin
            rx_full_flag <= 1'b0; // [R2]
          end
        end
      end

      // serial engine
      div_cnt <= (state == S_IDLE || tick) ? 11'h000 : div_cnt + 11'h001;
      case (state)
        S_IDLE: begin
          sck_int  <= clk_polarity; // [R14]
          edge_cnt <= 5'h00;
          if (start) begin
            shreg         <= tx_buf;  // [R17]
            tx_empty_flag <= 1'b1;    // [R3]
            rx_pend       <= 1'b0;    // [R11] stale pending byte dies at a new start
            state         <= S_LEAD;
          end
        end
        S_LEAD: begin
          if (tick) begin
            state <= S_SHIFT; // [R22]
          end
        end
        S_SHIFT: begin
          if (tick) begin
            sck_int  <= ~sck_int; // [R18]
            edge_cnt <= next_edge;
            // phase zero samples odd edges, phase one even edges
            if (clk_phase ^ odd_edge) begin
              rx_bit <= din; // [R14]
            end
            if (clk_phase ? (odd_edge && next_edge != 5'h01) : !odd_edge) begin
              shreg <= ssm_shift(shreg, rx_bit, lsb_first_en); // [R13]
            end
            if (next_edge == `SSM_LAST_EDGE) begin
              state <= S_TAIL;
            end
          end
        end
        S_TAIL: begin
          if (tick) begin
            state <= S_IDLE;
            shreg <= fin_byte;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase

      // completion; a new byte beats a same-cycle clear of the flag
      if (done) begin
        if (!rx_full_flag || (svc && !rx_pend)) begin
          rx_data      <= fin_byte; // [R9]
          rx_full_flag <= 1'b1;     // [R1]
        end else begin
          pend_byte <= fin_byte;    // [R10]
          rx_pend   <= 1'b1;
        end
      end

      if (abort) begin
        state    <= S_IDLE; // [R16] [R20]
        edge_cnt <= 5'h00;
      end
      if (fault) begin
        mode_fault_flag                <= 1'b1; // [R4]
        cr1[`SSM_CR1_CTRL_SEL]         <= 1'b0; // [R20]
      end
    end
  end

  // ----------------------------------------------------------------
  // registered pin drivers and interrupt request
  // ----------------------------------------------------------------
  // one cycle of lag on all pins keeps clock and data aligned to each other
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ss_n_out <= 1'b1;
      ss_n_oe  <= 1'b0;
      sck_out  <= 1'b0;
      sck_oe   <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
      irq_req  <= 1'b0;
    end else begin
      ss_n_out <= (state == S_IDLE);                                       // [R19]
      ss_n_oe  <= master_active & mode_fault_detect_en & select_out_en;    // [R19] [R12]
      sck_out  <= sck_int;                                                 // [R18]
      sck_oe   <= master_active;                                           // [R20]
      mosi_out <= dout;                                                    // [R17]
      mosi_oe  <= master_active & (~bidir_pin_mode | bidir_out_en);        // [R20]
      miso_out <= 1'b0; // slave output path is not part of this core
      miso_oe  <= 1'b0;
      irq_req  <= irq_en & (mode_fault_flag | rx_full_flag);               // [R21]
    end
  end

endmodule
`default_nettype wire

// *** ssm_chk.sv ***
// checker for ssm_core: bus handshakes and serial frame shape
// assumes one clock domain and a bind onto the core's ports
`timescale 1ns/100ps
`default_nettype none
module ssm_chk (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        ss_n_out,
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        mosi_oe,
  input wire logic        irq_req
);
  logic [4:0] edge_cnt;
  logic       sck_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // clock toggles seen inside one frame
  // ----------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt <= 5'h00;
      sck_q    <= 1'b0;
    end else begin
      sck_q <= sck_out;
      if (ss_n_out) edge_cnt <= 5'h00;
      else if (sck_out != sck_q) edge_cnt <= edge_cnt + 5'h01;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer not in time");
  chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer not in time");
  chk_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready) else $error("read answer not released");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  chk_sck_lead: assert property ($fell(ss_n_out) |-> $stable(sck_out) ##1 $stable(sck_out))
    else $error("clock moved with select");
  chk_frame_edges: assert property ($rose(ss_n_out) |-> edge_cnt == 5'h10)
    else $error("frame toggle count wrong");
  chk_frame_drive: assert property ($fell(ss_n_out) |-> sck_oe && mosi_oe)
    else $error("frame without driven pins");
  cover property ($rose(ss_n_out));
  cover property ($rose(irq_req));
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
`default_nettype wire

// *** ssm_spi_peer.sv ***
// behavioural remote slave: polarity 0, phase 0, msb first
// assumes select and clock from the core; replies count up from 8'h5A
`timescale 1ns/100ps
`default_nettype none
module ssm_spi_peer (
  input wire logic        sel_n,
  input wire logic        sck,
  input wire logic        mosi,
  output var logic        miso,
  output var logic [7:0]  got,
  output var int          frames
);
  logic [7:0] tx;
  logic [7:0] sh;
  int         bitn;
  initial begin
    tx     = 8'h5A;
    miso   = 1'b0;
    frames = 0;
  end
  // first bit out as soon as selected
  always @(negedge sel_n) begin
    bitn = 0;
    miso = tx[7];
  end
  // sample on odd edges, shift on even edges
  always @(posedge sck) if (!sel_n) sh = {sh[6:0], mosi};
  always @(negedge sck) begin
    if (!sel_n) begin
      bitn = bitn + 1;
      if (bitn < 8) miso = tx[7 - bitn];
    end
  end
  // released line shows no stale value; only a clocked frame counts, so the
  // select leaving its unknown power-up level is not taken for a frame
  always @(posedge sel_n) begin
    if (bitn > 0) begin
      got    = sh;
      frames = frames + 1;
      tx     = tx + 8'h01;
    end
    miso = ~miso;
  end
endmodule
`default_nettype wire

// *** spi_status_data_master_tb_top.sv ***
// testbench for ssm_core: register tasks over axi4-lite, remote slave model
// assumes ssm_chk and ssm_spi_peer compiled before this file
`timescale 1ns/100ps
`default_nettype none
module spi_status_data_master_tb_top;
  localparam logic [11:0] CR1 = 12'h3A0, CR2 = 12'h3A4, BAUD = 12'h3A8;
  localparam logic [11:0] ST = 12'h3AC, DAT = 12'h3B4;
  logic        core_clk = 1'b0, rst_n = 1'b0, ss_ext = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        ss_n_out, ss_n_oe, sck_out, sck_oe, mosi_out, mosi_oe;
  logic        miso_in, miso_out, miso_oe, irq_req;
  logic [7:0]  got;
  int          frames, fails = 0, checks = 0, cyc = 0;
  wire         ss_n_in = ss_n_oe ? ss_n_out : ss_ext;
  ssm_core dut_u (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe),
    .sck_in(1'b0), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_out),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(miso_out),
    .miso_oe(miso_oe), .irq_req(irq_req));
  ssm_spi_peer peer_u (.sel_n(ss_n_out), .sck(sck_out), .mosi(mosi_out),
    .miso(miso_in), .got(got), .frames(frames));
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      complete_run();
    end
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks = checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    rd(a, rd_v);
    cmp(rd_v, e);
  endtask
  task automatic wait_frames(input int n);
    while (frames < n) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(ST, 32'h20);
    rdc(DAT, 32'h00);
    rd(12'h3B0, rd_v);
    cmp({30'h0, rresp}, 32'h2);
    wr(ST, 8'hFF);
    cmp({30'h0, bresp}, 32'h0);
    rdc(ST, 32'h20);
    wr(BAUD, 8'h11);
    rdc(BAUD, 32'h11);
    wr(CR2, 8'h10);
    wr(CR1, 8'h52);
    // the earlier status read armed the first write; the second finds no arm
    wr(DAT, 8'h3C);
    wr(DAT, 8'h99);
    rdc(ST, 32'h20);
    cmp(frames, 0);
    wait_frames(1);
    cmp(got, 8'h3C);
    rdc(ST, 32'hA0);
    rdc(DAT, 32'h5A);
    rdc(ST, 32'h20);
    wr(DAT, 8'h11);
    rdc(ST, 32'h20);
    wr(DAT, 8'h22);
    wait_frames(3);
    cmp(got, 8'h22);
    cmp(ss_n_out, 1'b1);
    rdc(ST, 32'hA0);
    rdc(DAT, 32'h5B);
    rdc(ST, 32'hA0);
    rdc(DAT, 32'h5C);
    rdc(ST, 32'h20);
    wr(CR1, 8'hD0);
    ss_ext <= 1'b0;
    repeat (6) @(posedge core_clk);
    rdc(ST, 32'h30);
    cmp(irq_req, 1'b1);
    cmp({ss_n_oe, sck_oe, mosi_oe, miso_oe, miso_out}, 32'h0);
    rdc(CR1, 32'hC0);
    ss_ext <= 1'b1;
    repeat (6) @(posedge core_clk);
    wr(CR1, 8'h52);
    rdc(ST, 32'h20);
    cmp(irq_req, 1'b0);
    complete_run();
  end
endmodule
bind ssm_core ssm_chk chk_u (.core_clk(core_clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .ss_n_out(ss_n_out), .sck_out(sck_out), .sck_oe(sck_oe),
  .mosi_oe(mosi_oe), .irq_req(irq_req));
`default_nettype wire
